// ==== src/adc_conversion_sequencer.sv ====
/*
 sequencer of a serial 8-bit multichannel converter with result fifo.
 assumes serial pins and the start pin are asynchronous; adc_code_i is the
 quantised sample on sys_clk_i, valid whenever a conversion ends.
*/
// Notes on behaviour
// RULE1: host pulses start pin low, 40ns minimum
// RULE2: mode 00 scans all channels, then eoc low; code scans only the channels set by the scan field of the conversion byte
// RULE3: eoc stays low until cs or start fall; code releases on start fall only in modes 00 and 01
// RULE4: host waits for eoc before chip select
// RULE5: no new start before eoc low
// RULE6: mode 01 start low tracks, one conversion
// RULE7: host adds 65us when reference wakes
// RULE8: mode 01 rising start converts, then eoc
// RULE9: averaged result pushed after n pulses, channel advances
// RULE10: mode 10 conversion byte starts full scan; code scans only the channels set by the scan field of the conversion byte
// RULE11: mode 11 one sclk conversion, result shifts out
// RULE12: host gives 16 sclk per conversion
// RULE13: host cs gap under 100us
// RULE14: host interleaves zero byte between conversions
// RULE15: host waits 65us with reference mode 00
// RULE16: short first byte continues, rest discarded
// RULE17: short second byte drops entry remainder
// RULE18: partial write updates bits from msb only
// RULE19: cs low before eoc aborts, fifo flushed
// RULE20: straight binary result, rounded average
// RULE21: clock select resets to mode 10
// RULE22: frame msb first, four zeros each side
// RULE23: din on sclk rise, dout on fall
// RULE24: averaging counts 4, 8, 16 or 32
// RULE25: sixteen entries, drained in conversion order
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_defines.svh"
module adc_conversion_sequencer #(
    parameter int NUM_CH     = 16,
    parameter int FIFO_DEPTH = 16
) (
    // clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       resetn_i,
    // serial port
    input  wire logic       cs_n_i,
    input  wire logic       sclk_i,
    input  wire logic       din_i,
    output logic            dout_o,
    // conversion control pins
    input  wire logic       convert_start_n_i,
    output logic            eoc_n_o,
    // converter core
    input  wire logic [7:0] adc_code_i,
    output logic      [3:0] mux_channel_o,
    output logic            converter_awake_o,
    // configuration status
    output logic            clock_select_hi_o,
    output logic            clock_select_lo_o,
    output logic            reference_select_hi_o,
    output logic            reference_select_lo_o
);
    initial begin
        if (NUM_CH < 2 || NUM_CH > 16) $error("channel count out of range");
    end
    typedef struct packed {
        logic [1:0] cs_s, ck_s, di_s, cv_s;
        logic       cs_q, ck_q, cv_q;
        adc_seq_pkg::seq_state_e state;
        logic [15:0] timer;
        logic        eoc_n;
        logic clock_select_hi, clock_select_lo;
        logic reference_select_hi, reference_select_lo;
        logic averaging_on, average_count_hi, average_count_lo;
        logic [1:0]  nscan;
        logic [3:0]  chsel;
        logic [1:0]  scan;
        logic [3:0]  chan;
        logic [4:0]  left;
        logic [12:0] acc;
        logic [5:0]  avg_done;
        logic [7:0]  rx;
        logic [3:0]  rx_cnt;
        logic [15:0] tx;
        logic [4:0]  tx_cnt;
        logic [4:0]  entry_end;
        logic        dout;
        logic        sclk_load, sclk_frame;
    } seq_s;
    seq_s r_reg, r_next;
    logic       fifo_push, fifo_pop, fifo_flush, fifo_empty, fifo_full;
    logic [7:0] fifo_head, fifo_wdata;
    logic       cs_fall, cs_rise, ck_rise, ck_fall, cv_fall, cv_rise;
    logic       pin_mode, conv_wr, conv_end, load_tx;
    logic [1:0] mode;
    logic [2:0] avg_sh;
    logic [5:0] avg_target;
    assign cs_fall  = r_reg.cs_q & ~r_reg.cs_s[1];
    assign cs_rise  = ~r_reg.cs_q & r_reg.cs_s[1];
    assign ck_rise  = ~r_reg.ck_q & r_reg.ck_s[1];
    assign ck_fall  = r_reg.ck_q & ~r_reg.ck_s[1];
    assign cv_fall  = r_reg.cv_q & ~r_reg.cv_s[1];
    assign cv_rise  = ~r_reg.cv_q & r_reg.cv_s[1];
    assign mode     = {r_reg.clock_select_hi, r_reg.clock_select_lo};
    assign pin_mode = ~r_reg.clock_select_hi; // RULE21
    // no averaging in mode 11
    assign avg_sh     = (r_reg.averaging_on && mode != `MODE_REG_SCLK) ?
                        3'(2 + {r_reg.average_count_hi, r_reg.average_count_lo}) : 3'h0;
    assign avg_target = 6'(6'h1 << avg_sh); // RULE24
    function automatic logic [3:0] first_chan(input logic [1:0] sc, input logic [3:0] n);
        first_chan = (sc == `SCAN_LOW) ? 4'h0 : n;
    endfunction : first_chan
    always_comb begin
        logic [7:0]  b, m;
        logic [12:0] sum;
        logic        last;
        b = 8'h00; m = 8'h00; sum = 13'h0000; last = 1'b0;
        r_next     = r_reg;
        r_next.sclk_load = 1'b0;
        fifo_push  = 1'b0; fifo_pop = 1'b0; fifo_flush = 1'b0;
        fifo_wdata = 8'h00; conv_wr = 1'b0; conv_end = 1'b0; load_tx = 1'b0;
        r_next.cs_s = {r_reg.cs_s[0], cs_n_i};
        r_next.ck_s = {r_reg.ck_s[0], sclk_i};
        r_next.di_s = {r_reg.di_s[0], din_i};
        r_next.cv_s = {r_reg.cv_s[0], convert_start_n_i};
        r_next.cs_q = r_reg.cs_s[1];
        r_next.ck_q = r_reg.ck_s[1];
        r_next.cv_q = r_reg.cv_s[1];
        // serial input: sampled on sclk rise
        if (ck_rise && !r_reg.cs_s[1]) begin
            r_next.rx     = {r_reg.rx[6:0], r_reg.di_s[1]}; // RULE23
            r_next.rx_cnt = r_reg.rx_cnt + 4'h1;
            if (r_reg.rx_cnt == `BYTE_BITS - 4'h1) begin
                b = r_next.rx; m = 8'hff; r_next.rx_cnt = 4'h0;
            end
        end
        if (cs_rise && r_reg.rx_cnt != 4'h0) begin
            m = 8'(8'hff << (`BYTE_BITS - r_reg.rx_cnt)); // RULE18
            b = 8'(r_reg.rx << (`BYTE_BITS - r_reg.rx_cnt));
            r_next.rx_cnt = 4'h0;
        end
        if (m[7] && b[7] && m == 8'hff) begin
            conv_wr        = 1'b1;
            r_next.chsel   = b[6:3];
            r_next.scan    = b[2:1];
            r_next.chan    = first_chan(b[2:1], b[6:3]);
            r_next.avg_done = 6'h00;
            r_next.acc     = 13'h0000;
        end else if (m[6] && b[7:6] == 2'h1) begin
            // untouched bits keep their old values on a short write
            if (m[5]) r_next.clock_select_hi     = b[5]; // RULE18
            if (m[4]) r_next.clock_select_lo     = b[4];
            if (m[3]) r_next.reference_select_hi = b[3];
            if (m[2]) r_next.reference_select_lo = b[2];
        end else if (m[5] && b[7:5] == 3'h1) begin
            if (m[4]) r_next.averaging_on     = b[4];
            if (m[3]) r_next.average_count_hi = b[3];
            if (m[2]) r_next.average_count_lo = b[2];
            if (m[1]) r_next.nscan[1]         = b[1];
            if (m[0]) r_next.nscan[0]         = b[0];
        end else if (m == 8'hff && b[7:4] == 4'h1) begin
            fifo_flush = 1'b1;
            if (!b[3]) begin
                r_next.clock_select_hi = 1'b1; r_next.clock_select_lo = 1'b0;
                r_next.reference_select_hi = 1'b0; r_next.reference_select_lo = 1'b0;
                r_next.averaging_on = 1'b0; r_next.average_count_hi = 1'b0;
                r_next.average_count_lo = 1'b0; r_next.nscan = 2'h0;
            end
        end
        // scan sequencer
        unique case (r_reg.state)
            adc_seq_pkg::ST_IDLE: begin
                if ((mode == `MODE_PIN_SCAN && cv_rise) ||
                    (mode == `MODE_REG_SCAN && conv_wr)) begin
                    r_next.state = adc_seq_pkg::ST_WAKE; // RULE2 RULE10
                    r_next.timer = 16'(`WAKE_CYC);
                    r_next.chan  = conv_wr ? r_next.chan : first_chan(r_reg.scan, r_reg.chsel);
                    r_next.left  = 5'({r_reg.nscan, 2'h3});
                    r_next.avg_done = 6'h00;
                    r_next.acc   = 13'h0000;
                end else if (mode == `MODE_PIN_EACH && cv_fall) begin
                    r_next.state = adc_seq_pkg::ST_TRACK; // RULE6
                end
            end
            adc_seq_pkg::ST_TRACK: begin
                if (cv_rise) begin
                    r_next.state = adc_seq_pkg::ST_CONV; // RULE8
                    r_next.timer = 16'(`CONV_CYC);
                end
            end
            adc_seq_pkg::ST_WAKE: begin
                r_next.timer = r_reg.timer - 16'h1;
                if (r_reg.timer == 16'h1) begin
                    r_next.state = adc_seq_pkg::ST_CONV;
                    r_next.timer = 16'(`CONV_CYC);
                end
            end
            adc_seq_pkg::ST_CONV: begin
                r_next.timer = r_reg.timer - 16'h1;
                if (r_reg.timer == 16'h1) begin
                    conv_end = 1'b1;
                    sum = r_reg.acc + 13'(adc_code_i);
                    r_next.acc = sum;
                    r_next.avg_done = r_reg.avg_done + 6'h1;
                    unique case (r_reg.scan)
                        `SCAN_LOW:    last = (r_reg.chan >= r_reg.chsel);
                        `SCAN_HIGH:   last = (r_reg.chan == 4'(NUM_CH - 1));
                        `SCAN_REPEAT: last = (r_reg.left == 5'h0);
                        `SCAN_SINGLE: last = 1'b1;
                    endcase
                    if (r_reg.avg_done + 6'h1 == avg_target) begin
                        fifo_push  = 1'b1; // RULE9
                        // half an lsb added before the shift rounds to nearest
                        fifo_wdata = 8'((sum + ((13'h1 << avg_sh) >> 1)) >> avg_sh); // RULE20
                        r_next.acc = 13'h0000;
                        r_next.avg_done = 6'h00;
                        r_next.left = r_reg.left - 5'h1;
                        if (r_reg.scan != `SCAN_REPEAT) r_next.chan = r_reg.chan + 4'h1;
                        if (last) begin
                            r_next.chan = first_chan(r_reg.scan, r_reg.chsel);
                            r_next.left = 5'({r_reg.nscan, 2'h3});
                        end
                    end
                    if (mode == `MODE_PIN_EACH || (last && fifo_push)) begin
                        r_next.state = adc_seq_pkg::ST_IDLE;
                        r_next.eoc_n = 1'b0; // RULE2 RULE8
                    end else begin
                        r_next.timer = 16'(`CONV_CYC);
                    end
                end
            end
        endcase
        // eoc release; a completion in the same cycle still wins
        if ((cs_fall || (pin_mode && cv_fall)) && !(conv_end && !r_next.eoc_n)) begin
            r_next.eoc_n = 1'b1; // RULE3
        end
        if (cs_fall && r_reg.state != adc_seq_pkg::ST_IDLE) begin
            r_next.state = adc_seq_pkg::ST_IDLE; // RULE19
            fifo_flush   = 1'b1;
            fifo_push    = 1'b0;
        end
        // serial output
        // mux settles a cycle after the byte, so the frame is taken one cycle late
        if (conv_wr && mode == `MODE_REG_SCLK) begin
            r_next.sclk_load = 1'b1;
            r_next.sclk_frame = 1'b1;
            r_next.tx_cnt = 5'h00; r_next.entry_end = `FRAME_BITS;
        end else if (r_reg.sclk_load) begin
            r_next.tx = {4'h0, adc_code_i, 4'h0}; // RULE11 RULE22
        end else if (cs_fall && r_reg.tx_cnt == 5'h00 && !r_reg.sclk_frame) begin
            // a cs gap before the clocks keeps the pending frame
            load_tx = 1'b1; // RULE13
        end else if (ck_rise && !r_reg.cs_s[1]) begin
            r_next.sclk_frame = 1'b0;
            r_next.tx_cnt = r_reg.tx_cnt + 5'h1;
            if (r_reg.tx_cnt + 5'h1 == r_reg.entry_end) fifo_pop = 1'b1; // RULE25
        end else if (ck_fall && !r_reg.cs_s[1]) begin
            if (r_reg.tx_cnt == r_reg.entry_end) load_tx = 1'b1;
            else if (r_reg.tx_cnt != 5'h00) r_next.tx = {r_reg.tx[14:0], 1'b0};
        end else if (cs_rise && r_reg.tx_cnt != 5'h00) begin
            if (r_reg.tx_cnt < 5'(`BYTE_BITS)) begin
                r_next.entry_end = r_reg.tx_cnt + 5'(`BYTE_BITS); // RULE16
            end else if (r_reg.tx_cnt < r_reg.entry_end) begin
                fifo_pop = 1'b1; // RULE17
                r_next.tx_cnt = 5'h00;
            end
        end
        if (load_tx) begin
            r_next.tx = {4'h0, fifo_head, 4'h0}; // RULE22
            r_next.tx_cnt = 5'h00; r_next.entry_end = `FRAME_BITS;
        end
        if (ck_fall || cs_fall) r_next.dout = r_next.tx[15]; // RULE23
    end
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            r_reg <= '0;
            r_reg.cs_s <= 2'h3; r_reg.ck_s <= 2'h0; r_reg.cv_s <= 2'h3;
            r_reg.cs_q <= 1'b1; r_reg.cv_q <= 1'b1; r_reg.eoc_n <= 1'b1;
            r_reg.clock_select_hi <= 1'b1; // RULE21
            r_reg.entry_end <= `FRAME_BITS;
        end else begin
            r_reg <= r_next;
        end
    end
    result_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk_i (sys_clk_i),
        .resetn_i  (resetn_i),
        .push_i    (fifo_push),
        .wdata_i   (fifo_wdata),
        .pop_i     (fifo_pop),
        .flush_i   (fifo_flush),
        .rdata_o   (fifo_head),
        .empty_o   (fifo_empty),
        .full_o    (fifo_full)
    );
    assign dout_o                = r_reg.dout;
    assign eoc_n_o               = r_reg.eoc_n;
    assign mux_channel_o         = r_reg.chan;
    assign converter_awake_o     = (r_reg.state != adc_seq_pkg::ST_IDLE);
    assign clock_select_hi_o     = r_reg.clock_select_hi;
    assign clock_select_lo_o     = r_reg.clock_select_lo;
    assign reference_select_hi_o = r_reg.reference_select_hi;
    assign reference_select_lo_o = r_reg.reference_select_lo;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    sequence s_pin_go;
        mode == `MODE_PIN_SCAN && cv_rise && r_reg.state == adc_seq_pkg::ST_IDLE && !cs_fall;
    endsequence
    sequence s_waking;
        r_reg.state == adc_seq_pkg::ST_WAKE ##1 r_reg.state == adc_seq_pkg::ST_WAKE;
    endsequence
    a_eoc_hold: assert property (!eoc_n_o && !cs_fall && !(pin_mode && cv_fall) |=> !eoc_n_o) // RULE3
        else $error("eoc released without cs or start fall");
    a_pin_start: assert property (s_pin_go |=> s_waking) // RULE2
        else $error("start pin did not wake the scan");
    a_reg_start: assert property (mode == `MODE_REG_SCAN && conv_wr && !cs_fall &&
        r_reg.state == adc_seq_pkg::ST_IDLE |=> r_reg.state == adc_seq_pkg::ST_WAKE) // RULE10
        else $error("conversion byte did not start scan");
    a_track_conv: assert property (mode == `MODE_PIN_EACH && cv_rise && !cs_fall &&
        r_reg.state == adc_seq_pkg::ST_TRACK |=> r_reg.state == adc_seq_pkg::ST_CONV) // RULE8
        else $error("start rise did not begin conversion");
    a_abort_flush: assert property (cs_fall && r_reg.state != adc_seq_pkg::ST_IDLE |=>
        r_reg.state == adc_seq_pkg::ST_IDLE ##1 fifo_empty) // RULE19
        else $error("cs during conversion did not abort");
    a_push_avg: assert property (fifo_push |-> conv_end && r_reg.avg_done + 6'h1 == avg_target) // RULE9
        else $error("result pushed before averaging count");
    a_sclk_frame: assert property (conv_wr && mode == `MODE_REG_SCLK |=> ##1 // RULE11
        r_reg.tx == {4'h0, $past(adc_code_i), 4'h0} && $past(mux_channel_o) == r_reg.chsel)
        else $error("sclk conversion frame wrong");
    a_dout_edge: assert property ($changed(dout_o) |-> $past(ck_fall || cs_fall)) // RULE23
        else $error("dout moved off a falling edge");
    a_short_first: assert property (cs_rise && r_reg.tx_cnt != 5'h00 && r_reg.tx_cnt < 5'h08 &&
        !conv_wr |=> r_reg.entry_end == $past(r_reg.tx_cnt) + 5'h08) // RULE16
        else $error("short first byte not extended");
endmodule : adc_conversion_sequencer
`default_nettype wire

// ==== src/adc_seq_defines.svh ====
/*
 constants of the conversion sequencer: field codes, reset values, timing counts.
 assumes a 100 MHz system clock.
*/
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH
`define SYS_CLK_MHZ     100
`define WAKE_NS         500
`define CONV_NS         1000
`define WAKE_CYC        ((`WAKE_NS * `SYS_CLK_MHZ + 999) / 1000)
`define CONV_CYC        ((`CONV_NS * `SYS_CLK_MHZ + 999) / 1000)
`define CKSEL_RESET     2'h2
`define MODE_PIN_SCAN   2'h0
`define MODE_PIN_EACH   2'h1
`define MODE_REG_SCAN   2'h2
`define MODE_REG_SCLK   2'h3
`define SCAN_LOW        2'h0
`define SCAN_HIGH       2'h1
`define SCAN_REPEAT     2'h2
`define SCAN_SINGLE     2'h3
`define FRAME_BITS      5'h10
`define BYTE_BITS       4'h8
`endif

// ==== src/adc_seq_pkg.sv ====
/*
 types shared by the sequencer.
 assumes adc_seq_defines.svh carries the numbers.
*/
package adc_seq_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_TRACK, ST_WAKE, ST_CONV} seq_state_e;
endpackage : adc_seq_pkg

// ==== src/result_fifo.sv ====
/*
 result fifo: width and depth parameters, registered head word.
 assumes pushes when full and pops when empty are dropped by design.
*/
`timescale 1ns/1ps
`default_nettype none
module result_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             sys_clk_i,
    input  wire logic             resetn_i,
    // control
    input  wire logic             push_i,
    input  wire logic [WIDTH-1:0] wdata_i,
    input  wire logic             pop_i,
    input  wire logic             flush_i,
    // status
    output logic      [WIDTH-1:0] rdata_o,
    output logic                  empty_o,
    output logic                  full_o
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");
    end
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
        logic [WIDTH-1:0]            head;
    } fifo_s;
    fifo_s r_reg, r_next;
    always_comb begin
        r_next = r_reg;
        if (flush_i) begin
            r_next.wr  = '0;
            r_next.rd  = '0;
            r_next.cnt = '0;
        end else begin
            if (pop_i && r_reg.cnt != '0) begin
                r_next.rd  = r_reg.rd + 1'b1;
                r_next.cnt = r_next.cnt - 1'b1;
            end
            // full pushes are lost rather than overwrite older entries
            if (push_i && r_reg.cnt != DEPTH[AW:0]) begin
                r_next.mem[r_reg.wr] = wdata_i;
                r_next.wr            = r_reg.wr + 1'b1;
                r_next.cnt           = r_next.cnt + 1'b1;
            end
        end
        r_next.head = (r_next.cnt == '0) ? '0 : r_next.mem[r_next.rd]; // RULE25
    end
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) r_reg <= '0;
        else           r_reg <= r_next;
    end
    assign rdata_o = r_reg.head;
    assign empty_o = (r_reg.cnt == '0);
    assign full_o  = (r_reg.cnt == DEPTH[AW:0]);
endmodule : result_fifo
`default_nettype wire

// ==== tb/adc_conversion_sequencer_tb_top.sv ====
/*
 testbench of the conversion sequencer: host model calls with expected values.
 assumes adc_code_i follows the multiplexer, so each result names its channel.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_defines.svh"
module adc_conversion_sequencer_tb_top;
    logic        sys_clk;
    logic        resetn;
    logic        cs_n;
    logic        sclk;
    logic        din;
    logic        dout;
    logic        start_n;
    logic        eoc_n;
    logic [3:0]  mux_ch;
    logic        awake;
    logic [3:0]  cfg;
    logic [23:0] rx;
    logic        seen;
    int          error_cnt;
    int          total_checks;
    logic [3:0]  code_hi;
    wire  [7:0]  adc_code = {code_hi, mux_ch};

    always #5 sys_clk = ~sys_clk;

    adc_conversion_sequencer DUT (
        .sys_clk_i(sys_clk), .resetn_i(resetn), .cs_n_i(cs_n), .sclk_i(sclk),
        .din_i(din), .dout_o(dout), .convert_start_n_i(start_n), .eoc_n_o(eoc_n),
        .adc_code_i(adc_code), .mux_channel_o(mux_ch), .converter_awake_o(awake),
        .clock_select_hi_o(cfg[3]), .clock_select_lo_o(cfg[2]),
        .reference_select_hi_o(cfg[1]), .reference_select_lo_o(cfg[0]));

    spi_host_model host (
        .sys_clk_i(sys_clk), .cs_n_o(cs_n), .sclk_o(sclk), .din_o(din),
        .convert_start_n_o(start_n), .dout_i(dout), .eoc_n_i(eoc_n));

    task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] b);
        host.xfer({16'h0000, b}, 8, rx);
    endtask : wr

    task automatic rd(input logic [15:0] exp, input string what);
        host.xfer(24'h000000, 16, rx);
        check(rx, {8'h00, exp}, what);
    endtask : rd

    task automatic eoc_within(input int cyc);
        host.wait_eoc(cyc, seen);
        check({23'h0, seen}, 24'h000001, "eoc not seen");
    endtask : eoc_within

    task automatic print_verdict;
        if (error_cnt == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict

    // whole run is about sixteen thousand cycles
    initial begin
        #800us;
        error_cnt++;
        print_verdict();
    end

    initial begin
        sys_clk      = 1'b0;
        resetn       = 1'b0;
        error_cnt    = 0;
        total_checks = 0;
        code_hi      = 4'ha;
        repeat (5) @(negedge sys_clk);
        resetn = 1'b1;
        host.wait_clk(3);
        check({20'h0, cfg}, 24'h000008, "reset config");
        check({22'h0, eoc_n, awake}, 24'h000002, "reset eoc awake");
        // mode 10: single conversion of channel 2
        wr(8'h96);
        eoc_within(`WAKE_CYC + `CONV_CYC + 60);
        host.wait_clk(200);
        check({23'h0, eoc_n}, 24'h000000, "eoc held");
        rd(16'h0a20, "mode 10 frame");
        check({23'h0, eoc_n}, 24'h000001, "eoc after cs");
        // mode 00: channels 0..3, partial reads
        wr(8'h40);
        check({20'h0, cfg}, 24'h000000, "mode 00 config");
        wr(8'h98);
        host.pulse_start(10);
        host.wait_clk(20);
        check({22'h0, eoc_n, awake}, 24'h000003, "mode 00 busy");
        eoc_within(`WAKE_CYC + 4 * `CONV_CYC + 60);
        check({23'h0, awake}, 24'h000000, "shut down");
        host.xfer(24'h0, 4, rx);
        host.xfer(24'h0, 8, rx);
        check(rx, 24'h0000a0, "first byte cut short");
        rd(16'h0a10, "entry 1");
        host.xfer(24'h0, 12, rx);
        rd(16'h0a30, "entry after cut");
        // cs during a scan aborts it
        host.pulse_start(10);
        host.wait_clk(100);
        rd(16'h0000, "read while busy");
        host.wait_clk(`WAKE_CYC + 4 * `CONV_CYC);
        check({22'h0, eoc_n, awake}, 24'h000002, "abort state");
        rd(16'h0000, "fifo after abort");
        // mode 11: sclk timed conversions back to back
        code_hi = 4'h5;
        wr(8'h78);
        host.xfer({8'hbe, 16'h0000}, 24, rx);
        check(rx[15:0], 16'h0570, "mode 11 ch 7");
        host.xfer({8'hc6, 16'h0000}, 24, rx);
        check(rx[15:0], 16'h0580, "mode 11 ch 8");
        // reference mode 00: cs held high between byte and clocks
        wr(8'h70);
        check({20'h0, cfg}, 24'h00000c, "mode 11 ref 00 config");
        wr(8'hce);
        host.wait_clk(6500);
        host.xfer(24'h000000, 16, rx);
        check(rx[15:0], 16'h0590, "mode 11 after cs gap");
        // mode 01 with 4-fold averaging on channels 14..15
        wr(8'h50);
        wr(8'h30);
        wr(8'hf2);
        for (int k = 1; k <= 4; k++) begin
            host.pulse_start(140);
            check({23'h0, eoc_n}, 24'h000001, "eoc cleared by start");
            eoc_within(`CONV_CYC + 60);
            check({20'h0, mux_ch}, (k < 4) ? 24'h00000e : 24'h00000f, "mux advance");
        end
        rd(16'h05e0, "averaged result");
        rd(16'h0000, "single averaged entry");
        // partial writes keep the bits not reached
        host.xfer(24'h000007, 4, rx);
        check({20'h0, cfg}, 24'h00000c, "4-bit write");
        host.xfer(24'h00001a, 6, rx);
        check({20'h0, cfg}, 24'h00000a, "6-bit write");
        wr(8'h10);
        check({20'h0, cfg}, 24'h000008, "register reset");
        // mode 10 repeated channel, then a fifo-only reset
        wr(8'hac);
        eoc_within(`WAKE_CYC + 4 * `CONV_CYC + 60);
        for (int k = 0; k < 3; k++) rd(16'h0550, "repeated channel");
        wr(8'h18);
        check({20'h0, cfg}, 24'h000008, "fifo-only reset config");
        rd(16'h0000, "fifo-only reset");
        print_verdict();
    end
endmodule : adc_conversion_sequencer_tb_top
`default_nettype wire

// ==== tb/spi_host_model.sv ====
/*
 host model: drives chip select, serial clock, data in and the start pin.
 assumes the bench calls its tasks; serial clock 160 ns, 8 system clocks a phase.
*/
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    // clock
    input  wire logic sys_clk_i,
    // pins toward the device
    output logic      cs_n_o,
    output logic      sclk_o,
    output logic      din_o,
    output logic      convert_start_n_o,
    // pins from the device
    input  wire logic dout_i,
    input  wire logic eoc_n_i
);
    initial begin
        cs_n_o            = 1'b1;
        sclk_o            = 1'b0;
        din_o             = 1'b0;
        convert_start_n_o = 1'b1;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask : wait_clk

    // n bits msb first; sclk stands low outside frames
    task automatic xfer(input logic [23:0] tx, input int n, output logic [23:0] rx);
        rx     = '0;
        cs_n_o = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            din_o = tx[i];
            wait_clk(8);
            rx[i]  = dout_i;
            sclk_o = 1'b1;
            wait_clk(8);
            sclk_o = 1'b0;
        end
        wait_clk(8);
        cs_n_o = 1'b1;
        // released line must not keep a valid-looking level
        din_o = ~din_o;
        wait_clk(8);
    endtask : xfer

    task automatic pulse_start(input int low_cyc);
        convert_start_n_o = 1'b0;
        wait_clk(low_cyc);
        convert_start_n_o = 1'b1;
    endtask : pulse_start

    // no chip select or new start until eoc is seen low
    task automatic wait_eoc(input int limit, output logic seen);
        seen = 1'b0;
        for (int i = 0; i < limit && !seen; i++) begin
            wait_clk(1);
            seen = !eoc_n_i;
        end
    endtask : wait_eoc
endmodule : spi_host_model
`default_nettype wire
